// ==== rtl/clock_fanout_serial_output_control.v ====
// two-wire slave receiver, output enable registers and clock control
`timescale 1ns/100ps
`include "clock_fanout_defines.vh"

module clock_fanout_serial_output_control #(
    parameter [`ADDR_W-1:0] DEV_ADDR = `DEV_ADDR_DEFAULT,
    parameter               REF_DIV  = `REF_DIV_DEFAULT,
    parameter               SETTLE_US = `SETTLE_US
) (
    input  wire                  clk_sys,
    input  wire                  reset,
    input  wire                  serialClock,
    input  wire                  serialDataIn,
    output reg                   serialDataOut,
    output reg                   serialDataOe,
    input  wire                  refClockLevel,
    input  wire                  refClockDivided,
    input  wire                  analogSupplyPin,
    output reg                   bufferLevel,
    output reg  [`NUM_PAIRS-1:0] pairDrive,
    output reg                   feedbackLevel,
    output reg                   feedbackDrive,
    output reg                   pllEnable,
    output reg                   pllBypass,
    output reg                   lowPowerMode,
    output reg                   pllSettling
);

    // settling interval in sys cycles, at least one
    localparam integer SETTLE_INT =
        (SETTLE_US * `SYS_CLK_KHZ) / 1000;
    localparam [`SETTLE_CNT_W-1:0] SETTLE_CYCLES =
        (SETTLE_INT < 1) ? {{(`SETTLE_CNT_W-1){1'b0}}, 1'b1} :
        SETTLE_INT[`SETTLE_CNT_W-1:0];

    // sys cycles per link bit at full rate, for reference
    localparam integer LINK_BIT_CYCLES =
        `SYS_CLK_KHZ / `LINK_RATE_KBPS;

    // ---------------------------------------------------------------
    // pin synchronisation
    wire [4:0] pinSync;
    wire       sclSync;
    wire       sdaSync;
    wire       refLevelSync;
    wire       analogOk;
    wire       refDivSync;

    two_flop_sync #(
        .WIDTH (5),
        .INIT  (`SYNC_IDLE)
    ) u_pin_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .d       ({serialClock, serialDataIn, refClockLevel,
                   analogSupplyPin, refClockDivided}),
        .q       (pinSync)
    );

    assign sclSync      = pinSync[4];
    assign sdaSync      = pinSync[3];
    assign refLevelSync = pinSync[2];
    assign analogOk     = pinSync[1];
    assign refDivSync   = pinSync[0];

    // ---------------------------------------------------------------
    // reference frequency detection
    wire refSlow;

    ref_freq_detect #(
        .REF_DIV (REF_DIV)
    ) u_freq_detect (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .refDivSync (refDivSync),
        .refSlow    (refSlow)
    );

    // ---------------------------------------------------------------
    // link line events
    reg  sclLast;
    reg  sdaLast;
    wire sclRise;
    wire sclFall;
    wire startSeen;
    wire stopSeen;

    always @(posedge clk_sys) begin
        if (reset) begin
            sclLast <= 1'b1;
            sdaLast <= 1'b1;
        end else begin
            sclLast <= sclSync;
            sdaLast <= sdaSync;
        end
    end

    // bit period is LINK_BIT_CYCLES sys cycles at full rate
    assign sclRise   = sclSync & ~sclLast;
    assign sclFall   = ~sclSync & sclLast;
    assign startSeen = sclSync & sclLast & sdaLast & ~sdaSync;
    assign stopSeen  = sclSync & sclLast & ~sdaLast & sdaSync;

    // ---------------------------------------------------------------
    // address decode used on each address byte
    function addrMatch;
        input [`REG_W-1:0] addrByte;
        input [`ADDR_W-1:0] own;
        begin
            addrMatch = (addrByte[`ADDR_MSB:`ADDR_LSB] == own) &&
                        (addrByte[`RW_BIT] == 1'b0);
        end
    endfunction

    // ---------------------------------------------------------------
    // slave receiver state machine
    reg [2:0]                state;
    reg [2:0]                next_state;
    reg [`BIT_COUNT_W-1:0]   bitCount;
    reg [`REG_W-1:0]         shiftReg;
    reg [`REG_INDEX_W-1:0]   regIndex;
    reg [`REG_W-1:0]         enableReg0;
    reg [`REG_W-1:0]         enableReg1;
    wire                     byteDone;

    assign byteDone = sclFall && (bitCount == `BITS_PER_BYTE);

    always @* begin
        next_state = state;
        case (state)
            `ST_IDLE: begin
                next_state = `ST_IDLE;
            end
            `ST_ADDR: begin
                if (byteDone) begin
                    if (addrMatch(shiftReg, DEV_ADDR)) begin
                        next_state = `ST_ACK;
                    end else begin
                        // reads and foreign addresses are not answered
                        next_state = `ST_IGNORE;
                    end
                end
            end
            `ST_ACK: begin
                if (sclFall) begin
                    next_state = `ST_DATA;
                end
            end
            `ST_DATA: begin
                if (byteDone) begin
                    if (regIndex < `REG_COUNT) begin
                        next_state = `ST_ACK;
                    end else begin
                        next_state = `ST_IGNORE;
                    end
                end
            end
            `ST_IGNORE: begin
                next_state = `ST_IGNORE;
            end
            default: begin
                next_state = `ST_IDLE;
            end
        endcase
        // start and stop override any state
        if (startSeen) begin
            next_state = `ST_ADDR;
        end else if (stopSeen) begin
            next_state = `ST_IDLE;
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            state <= `ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // bit shifting and counting
    always @(posedge clk_sys) begin
        if (reset) begin
            bitCount <= {`BIT_COUNT_W{1'b0}};
            shiftReg <= {`REG_W{1'b0}};
        end else if (startSeen || stopSeen) begin
            bitCount <= {`BIT_COUNT_W{1'b0}};
        end else if (state == `ST_ADDR || state == `ST_DATA) begin
            if (sclRise) begin
                shiftReg <= {shiftReg[`REG_W-2:0], sdaSync};
                bitCount <= bitCount + 1'b1;
            end
        end else if (state == `ST_ACK) begin
            bitCount <= {`BIT_COUNT_W{1'b0}};
        end
    end

    // register index restarts at the first register each transfer
    always @(posedge clk_sys) begin
        if (reset) begin
            regIndex <= {`REG_INDEX_W{1'b0}};
        end else if (startSeen) begin
            regIndex <= {`REG_INDEX_W{1'b0}};
        end else if (state == `ST_DATA && byteDone &&
                     regIndex < `REG_COUNT) begin
            regIndex <= regIndex + 1'b1;
        end
    end

    // enable registers, all set at power-up
    always @(posedge clk_sys) begin
        if (reset) begin
            enableReg0 <= `REG_RESET;
            enableReg1 <= `REG_RESET;
        end else if (state == `ST_DATA && byteDone && !startSeen &&
                     !stopSeen) begin
            if (regIndex == 0) begin
                enableReg0 <= shiftReg;
            end else if (regIndex == 1) begin
                enableReg1 <= shiftReg;
            end
        end
    end

    // acknowledge drive: open drain, only ever pulls low
    always @(posedge clk_sys) begin
        if (reset) begin
            serialDataOut <= 1'b0;
            serialDataOe  <= 1'b0;
        end else begin
            serialDataOut <= 1'b0;
            if (next_state == `ST_ACK && state != `ST_ACK) begin
                serialDataOe <= 1'b1;
            end else if (next_state != `ST_ACK) begin
                serialDataOe <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // output and pll control
    wire [`REG_W*`REG_COUNT-1:0] enableBits;
    wire                         slowActive;
    wire                         pllWanted;

    assign enableBits = {enableReg1, enableReg0};
    // in bypass the reference is static by design, so no detection
    assign slowActive = refSlow & analogOk;
    assign pllWanted  = analogOk & ~refSlow;

    genvar g;
    generate
        for (g = 0; g < `NUM_PAIRS; g = g + 1) begin : g_pair
            always @(posedge clk_sys) begin
                if (reset) begin
                    pairDrive[g] <= 1'b1;
                end else begin
                    // upper unmapped bits are ignored
                    pairDrive[g] <= enableBits[g] & ~slowActive;
                end
            end
        end
    endgenerate

    always @(posedge clk_sys) begin
        if (reset) begin
            bufferLevel   <= 1'b0;
            feedbackLevel <= 1'b0;
            feedbackDrive <= 1'b1;
            pllEnable     <= 1'b0;
            pllBypass     <= 1'b0;
            lowPowerMode  <= 1'b0;
        end else begin
            bufferLevel   <= refLevelSync;
            feedbackLevel <= refLevelSync;
            // register writes never reach the feedback pair
            feedbackDrive <= ~slowActive;
            pllEnable     <= pllWanted;
            pllBypass     <= ~analogOk;
            lowPowerMode  <= slowActive;
        end
    end

    // ---------------------------------------------------------------
    // settling indication after power-up and pll restart
    reg [`SETTLE_CNT_W-1:0] settleCount;
    reg                     pllWantedLast;

    always @(posedge clk_sys) begin
        if (reset) begin
            settleCount   <= SETTLE_CYCLES;
            pllWantedLast <= 1'b0;
            pllSettling   <= 1'b1;
        end else begin
            pllWantedLast <= pllWanted;
            if (pllWanted && !pllWantedLast) begin
                settleCount <= SETTLE_CYCLES;
                pllSettling <= 1'b1;
            end else if (settleCount != 0) begin
                settleCount <= settleCount - 1'b1;
                pllSettling <= 1'b1;
            end else begin
                pllSettling <= 1'b0;
            end
        end
    end

endmodule // clock_fanout_serial_output_control

// ==== rtl/clock_fanout_defines.vh ====
// constants of the clock fan-out serial output control block
`ifndef CLOCK_FANOUT_DEFINES_VH
`define CLOCK_FANOUT_DEFINES_VH

// two-wire link
`define LINK_RATE_KBPS      100
`define SYS_CLK_KHZ         10000
`define ADDR_W              7
`define DEV_ADDR_DEFAULT    7'h2A
`define BIT_COUNT_W         4
`define BITS_PER_BYTE       4'h8
`define RW_BIT              0
// pin idle levels: scl, sda high, ref low, analog present, div low
`define SYNC_IDLE           5'h1A
`define ADDR_MSB            7
`define ADDR_LSB            1

// control registers
`define REG_COUNT           2
`define REG_W               8
`define REG_RESET           8'hFF
`define REG_INDEX_W         2
`define NUM_PAIRS           10

// low input frequency detection
`define LOW_FREQ_MHZ        20
`define REF_DIV_DEFAULT     64
`define DETECT_CNT_W        16

// pll stabilization interval
`define SETTLE_US           100
`define SETTLE_CNT_W        16

// link states
`define ST_IDLE             3'h0
`define ST_ADDR             3'h1
`define ST_ACK              3'h2
`define ST_DATA             3'h3
`define ST_IGNORE           3'h4

`endif

// ==== rtl/two_flop_sync.v ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module two_flop_sync #(
    parameter             WIDTH = 1,
    parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
    input  wire             clk_sys,
    input  wire             reset,
    input  wire [WIDTH-1:0] d,
    output reg  [WIDTH-1:0] q
);

    reg [WIDTH-1:0] stage1;

    always @(posedge clk_sys) begin
        if (reset) begin
            // idle levels, so no false edge follows reset
            stage1 <= INIT;
            q      <= INIT;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule // two_flop_sync

// ==== rtl/ref_freq_detect.v ====
// low input frequency detector on the divided reference clock
`timescale 1ns/100ps
`include "clock_fanout_defines.vh"
module ref_freq_detect #(
    parameter REF_DIV = `REF_DIV_DEFAULT
) (
    input  wire clk_sys,
    input  wire reset,
    input  wire refDivSync,
    output reg  refSlow
);

    // sys cycles per divided period at the threshold frequency
    localparam integer LIMIT_INT =
        (REF_DIV * `SYS_CLK_KHZ) / (`LOW_FREQ_MHZ * 1000);
    localparam [`DETECT_CNT_W-1:0] LIMIT = LIMIT_INT[`DETECT_CNT_W-1:0];

    reg                     refDivLast;
    reg [`DETECT_CNT_W-1:0] periodCount;
    wire                    refRise;

    assign refRise = refDivSync & ~refDivLast;

    always @(posedge clk_sys) begin
        if (reset) begin
            refDivLast  <= 1'b0;
            periodCount <= {`DETECT_CNT_W{1'b0}};
            refSlow     <= 1'b0;
        end else begin
            refDivLast <= refDivSync;
            if (refRise) begin
                periodCount <= {`DETECT_CNT_W{1'b0}};
                refSlow     <= (periodCount >= LIMIT);
            end else if (periodCount < LIMIT) begin
                periodCount <= periodCount + 1'b1;
            end else begin
                // no edge within one threshold period
                refSlow <= 1'b1;
            end
        end
    end

endmodule // ref_freq_detect

// ==== bench/clock_fanout_properties.sv ====
// assertion checker for the clock fan-out serial control block
`timescale 1ns/100ps
module clock_fanout_properties #(
    parameter REF_DIV = 64
) (
    input wire logic       clk_sys,
    input wire logic       reset,
    input wire logic       serialDataOut,
    input wire logic       serialDataOe,
    input wire logic       refClockLevel,
    input wire logic       refClockDivided,
    input wire logic       analogSupplyPin,
    input wire logic       bufferLevel,
    input wire logic [9:0] pairDrive,
    input wire logic       feedbackLevel,
    input wire logic       feedbackDrive,
    input wire logic       pllEnable,
    input wire logic       pllBypass,
    input wire logic       lowPowerMode
);
    localparam int QUIET = REF_DIV / 2 + 8;
    int   oeRun;
    int   quiet;
    logic refPrev;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // length of each acknowledge pulse, cycles without divided edges
    always @(posedge clk_sys) begin
        oeRun   <= (reset || !serialDataOe) ? 0 : oeRun + 1;
        refPrev <= refClockDivided;
        if (reset || !analogSupplyPin || refClockDivided != refPrev) begin
            quiet <= 0;
        end else begin
            quiet <= (quiet < 999) ? quiet + 1 : quiet;
        end
    end
    property p_ackLow; serialDataOe |-> !serialDataOut; endproperty
    a_ackLow: assert property (p_ackLow) else $error("ack not low");
    property p_ackShort; oeRun <= 12; endproperty
    a_ackShort: assert property (p_ackShort) else $error("ack too long");
    property p_slowOff;
        lowPowerMode |-> pairDrive == 10'h000 && !feedbackDrive && !pllEnable;
    endproperty
    a_slowOff: assert property (p_slowOff) else $error("slow not off");
    property p_slowEntry; quiet == QUIET |-> lowPowerMode; endproperty
    a_slowEntry: assert property (p_slowEntry) else $error("no slow");
    property p_bypass; !analogSupplyPin [*4] |=> pllBypass && !pllEnable;
    endproperty
    a_bypass: assert property (p_bypass) else $error("no bypass");
    property p_follow;
        (!lowPowerMode && $stable(refClockLevel)) [*5] |->
            bufferLevel == refClockLevel && feedbackLevel == refClockLevel;
    endproperty
    a_follow: assert property (p_follow) else $error("level wrong");
    property p_fbOn; !lowPowerMode |-> feedbackDrive; endproperty
    a_fbOn: assert property (p_fbOn) else $error("feedback off");
    property p_pairWrite;
        $changed(pairDrive) && !lowPowerMode && !$past(lowPowerMode) |->
            ##[0:1] serialDataOe;
    endproperty
    a_pairWrite: assert property (p_pairWrite) else $error("stray");
    property p_rstVal;
        disable iff (1'b0) $fell(reset) |->
            pairDrive == 10'h3FF && feedbackDrive && !serialDataOe;
    endproperty
    a_rstVal: assert property (p_rstVal) else $error("reset value");
    c_ack: cover property ($rose(serialDataOe));
    c_slow: cover property ($rose(lowPowerMode));
    c_bypass: cover property ($rose(pllBypass));
endmodule // clock_fanout_properties

// ==== bench/serial_master_model.sv ====
// behavioural two-wire bus master on the far side of the link
`timescale 1ns/100ps
module serial_master_model (
    output logic scl,
    output logic sdaLow,
    input  wire  sda
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // also serves as repeated start
    task automatic start;
        #33 sdaLow = 1'b0;
        #300 scl = 1'b1;
        #400 sdaLow = 1'b1;
        #400 scl = 1'b0;
        #200;
    endtask
    // 800 ns bit period, 400 ns per phase
    task automatic sendByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sdaLow = ~b[i];
            #200 scl = 1'b1;
            #400 scl = 1'b0;
            #200;
        end
        sdaLow = 1'b0;
        #200 scl = 1'b1;
        #300 ack = ~sda;
        #100 scl = 1'b0;
        #200;
    endtask
    task automatic stop;
        sdaLow = 1'b1;
        #200 scl = 1'b1;
        #400 sdaLow = 1'b0;
        #400;
    endtask
endmodule // serial_master_model

// ==== bench/tb_top.sv ====
// self-checking bench of the clock fan-out serial control block
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic [7:0]  a;
        logic [23:0] d;
        logic [1:0]  n;
        logic [9:0]  pd;
        logic [3:0]  ack;
    } row_t;
    localparam logic [7:0] WR = 8'h54;
    wire        scl, sdaLow;
    logic       clk_sys, reset, refRun, refClockLevel, refClockDivided;
    logic       analogSupplyPin, serialDataOut, serialDataOe, bufferLevel;
    logic [9:0] pairDrive;
    logic       feedbackLevel, feedbackDrive, pllEnable, pllBypass;
    logic       lowPowerMode, pllSettling;
    logic [3:0] acks;
    int         errors, checks;
    row_t       rows [7];
    wire        sda = !sdaLow && (serialDataOe ? serialDataOut : 1'b1);
    clock_fanout_serial_output_control #(.SETTLE_US(1)) uut (
        .clk_sys(clk_sys), .reset(reset), .serialClock(scl),
        .serialDataIn(sda), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .refClockLevel(refClockLevel),
        .refClockDivided(refClockDivided), .analogSupplyPin(analogSupplyPin),
        .bufferLevel(bufferLevel), .pairDrive(pairDrive),
        .feedbackLevel(feedbackLevel), .feedbackDrive(feedbackDrive),
        .pllEnable(pllEnable), .pllBypass(pllBypass),
        .lowPowerMode(lowPowerMode), .pllSettling(pllSettling)
    );
    serial_master_model m (.scl(scl), .sdaLow(sdaLow), .sda(sda));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // divided reference: one rise every 16 cycles while running
    initial begin
        refClockDivided = 1'b0;
        forever begin
            repeat (8) @(posedge clk_sys);
            #1 if (refRun) refClockDivided = ~refClockDivided;
        end
    end
    task automatic end_sim;
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        checks++;
        if (!ok) begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask
    task automatic waitFor(input logic slow, input logic v);
        for (int n = 0; n < 3000; n++) begin
            if ((slow ? lowPowerMode : pllSettling) === v) return;
            step(1);
        end
        errors++;
        $display("[ERR] %0t wait timeout", $time);
        end_sim();
    endtask
    task automatic xfer(input logic [7:0] a, input logic [23:0] d,
                        input int n);
        logic k;
        acks = 4'h0;
        m.start();
        m.sendByte(a, k);
        acks[0] = k;
        for (int i = 0; i < n; i++) begin
            m.sendByte(d[23-8*i -: 8], k);
            acks[i+1] = k;
        end
        m.stop();
        step(4);
    endtask
    initial begin
        reset = 1'b1;
        refRun = 1'b1;
        analogSupplyPin = 1'b1;
        refClockLevel = 1'b0;
        rows = '{'{WR, 24'h000000, 2'h2, 10'h000, 4'h7},
                 '{WR, 24'hA5FE00, 2'h2, 10'h2A5, 4'h7},
                 '{WR, 24'h3C0000, 2'h1, 10'h23C, 4'h3},
                 '{WR, 24'h0F0155, 2'h3, 10'h10F, 4'h7},
                 '{8'h56, 24'h000000, 2'h1, 10'h10F, 4'h0},
                 '{8'h55, 24'h000000, 2'h1, 10'h10F, 4'h0},
                 '{WR, 24'hFF0300, 2'h2, 10'h3FF, 4'h7}};
        step(20);
        reset = 1'b0;
        step(1);
        check(pairDrive === 10'h3FF, "enables not set");
        check(pllSettling === 1'b1, "no settle at reset");
        waitFor(1'b0, 1'b0);
        for (int r = 0; r < 7; r++) begin
            xfer(rows[r].a, rows[r].d, rows[r].n);
            check(acks === rows[r].ack, "ack pattern");
            check(pairDrive === rows[r].pd, "pair enables");
            check(feedbackDrive === 1'b1, "feedback off");
        end
        m.start();
        m.sendByte(WR, acks[0]);
        m.sendByte(8'h11, acks[1]);
        xfer(WR, 24'h220000, 2);
        check(pairDrive === 10'h022, "restart order");
        refRun = 1'b0;
        waitFor(1'b1, 1'b1);
        check(pairDrive === 10'h000, "slow drive");
        check(feedbackDrive === 1'b0, "slow feedback");
        check(pllEnable === 1'b0, "slow pll");
        refRun = 1'b1;
        waitFor(1'b1, 1'b0);
        check(pllSettling === 1'b1, "no resettle");
        waitFor(1'b0, 1'b0);
        check(pairDrive === 10'h022, "slow exit");
        analogSupplyPin = 1'b0;
        refRun = 1'b0;
        step(6);
        check(pllBypass === 1'b1 && pllEnable === 1'b0, "bypass");
        refClockLevel = 1'b1;
        step(6);
        check(bufferLevel === 1'b1 && feedbackLevel === 1'b1, "follow");
        step(60);
        check(lowPowerMode === 1'b0, "slow in bypass");
        refClockLevel = 1'b0;
        step(6);
        check(bufferLevel === 1'b0, "follow low");
        reset = 1'b1;
        analogSupplyPin = 1'b1;
        refRun = 1'b1;
        step(4);
        reset = 1'b0;
        step(1);
        check(pairDrive === 10'h3FF, "rerun enables");
        check(feedbackDrive === 1'b1, "rerun feedback");
        check(pllBypass === 1'b0, "rerun bypass");
        check(pllSettling === 1'b1, "rerun settle");
        end_sim();
    end
endmodule // tb_top
bind clock_fanout_serial_output_control clock_fanout_properties #(
    .REF_DIV(REF_DIV)) chk (
    .clk_sys(clk_sys), .reset(reset), .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe), .refClockLevel(refClockLevel),
    .refClockDivided(refClockDivided), .analogSupplyPin(analogSupplyPin),
    .bufferLevel(bufferLevel), .pairDrive(pairDrive),
    .feedbackLevel(feedbackLevel), .feedbackDrive(feedbackDrive),
    .pllEnable(pllEnable), .pllBypass(pllBypass),
    .lowPowerMode(lowPowerMode));
